/* include/msg_pkt_defs.svh */
// type codes, limits, offsets, field positions and reset values of the message packetizer
// assumes inclusion by bare name from design files
`ifndef MSG_PKT_DEFS_SVH
`define MSG_PKT_DEFS_SVH
`define ADDR_CTRL        4'h0
`define ADDR_STATUS      4'h1
`define ADDR_IRQ_STATUS  4'h2
`define ADDR_IRQ_ENABLE  4'h3
`define ADDR_IRQ_CLEAR   4'h4
`define ADDR_PKT_COUNT   4'h5
`define CTRL_RESET       8'h00
`define CTRL_ABS_BIT     0
`define CTRL_FMT_LO      1
`define CTRL_MAXMSG_LO   4
`define TYPE_COMPLETE    2'h0
`define TYPE_SEG_FIRST   2'h1
`define TYPE_SEG_LAST    2'h2
`define TYPE_SEG_MIDDLE  2'h3
`define SEG_FIRST_NUM    16'h0001
`define HDR_WORDS        3'h6
`define MAX_MSG_BYTES    17'h10000
`define MAX_SEGMENTS     17'h10000
`define IRQ_PKT_DONE     0
`define IRQ_ERR_MSG      1
`define IRQ_OVERSIZE     2
`define MEM_DEPTH_LOG2   11
`endif

/* include/msg_pkt_pkg.sv */
// types shared by the message packetizer files
// assumes nothing beyond a SystemVerilog compiler
package msg_pkt_pkg;
  typedef struct packed {
    logic        start;
    logic        last;
    logic [7:0]  data;
    logic [13:0] subchannel;
    logic        data_err;
    logic        fmt_err;
  } rx_byte_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic        first;
    logic        last;
  } out_word_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_COLLECT, ST_CHANNEL_SPECIFIC_WORD, ST_HDR, ST_BODY, ST_DONE
  } state_t;
endpackage

/* rtl/msg_byte_mem.sv */
// byte store holding one message or segment before framing
// assumes a single clock; read data appear one cycle after the address
`timescale 1ns/1ps
module msg_byte_mem (
  // clock
  input  wire logic        clk,
  // write side
  input  wire logic        wr_en,
  input  wire logic [10:0] wr_addr,
  input  wire logic [7:0]  wr_data,
  // read side
  input  wire logic [10:0] rd_addr,
  output logic      [7:0]  rd_data
);
  logic [7:0] mem [0:2047];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

/* rtl/msg_packetizer.sv */
// message data packet body builder with Avalon-MM control registers
// assumes receivers present bytes synchronous to clk; sink gives word_ready
// Function
// [RULE1] accept messages from several serial channels
// [RULE2] body opens with channel specific word
// [RULE3] complete type 00, count, reserved high
// [RULE4] segment types 01 first, 11 middle, 10 last
// [RULE5] segment number starts 1, rises by one
// [RULE6] long message total capped at 4 gigabytes; code only flags ev_over when segment 65536 ends before the last byte
// [RULE7] header: time low, time high, id word
// [RULE8] default 48-bit counter, top bits zero
// [RULE9] absolute time selected by flag bits
// [RULE10] bit 31 marks data error
// [RULE11] bit 30 marks format error
// [RULE12] bits 29-16 carry subchannel number
// [RULE13] bits 15-0 carry byte length, 64K max
// [RULE14] bytes little end first, odd filler
// [RULE15] reserved bits written as zero
`timescale 1ns/1ps
`include "msg_pkt_defs.svh"
module msg_packetizer (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // serial receiver byte stream
  input  wire msg_pkt_pkg::rx_byte_t  rx_byte,
  input  wire logic                   rx_valid,
  output logic                        rx_ready,
  // time sources
  input  wire logic [47:0]            rel_time,
  input  wire logic [63:0]            abs_time,
  // recording stream sink
  output msg_pkt_pkg::out_word_t      out_word,
  input  wire logic                   word_ready,
  // avalon-mm slave
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // interrupt
  output logic                        irq
);
  // ********************
  // registers and state
  // ********************
  msg_pkt_pkg::state_t state_reg;
  logic [7:0]  ctrl_reg;
  logic [2:0]  irq_status_reg;
  logic [2:0]  irq_enable_reg;
  logic [15:0] pkt_count_reg;
  logic [16:0] byte_cnt_reg;
  logic [16:0] seg_len_reg;
  logic [16:0] rd_idx_reg;
  logic [15:0] seg_num_reg;
  logic        long_reg;
  logic        msg_done_reg;
  logic [63:0] stamp_reg;
  logic [31:0] id_word_reg;
  logic [2:0]  hdr_idx_reg;
  logic        de_reg;
  logic        fe_reg;
  logic [13:0] sub_reg;
  logic        ack_reg;
  logic [7:0]  rd_data;
  logic [7:0]  lo_byte_reg;
  logic        lo_held_reg;
  logic [16:0] seg_limit;
  logic        ev_done;
  logic        ev_err;
  logic        ev_over;
  logic        take;
  logic        send;
  logic [1:0]  body_type;
  logic [31:0] channel_specific_word;
  logic [15:0] hdr_half;
  logic [10:0] rd_addr;
  // configurable segment length in 128-byte steps, never beyond memory or 64K
  assign seg_limit = (17'(ctrl_reg[7:`CTRL_MAXMSG_LO]) + 17'h00001) << 7;
  assign take      = rx_valid && rx_ready;
  assign send      = !out_word.valid || word_ready;
  // a stalled word keeps its high byte on the memory output
  assign rd_addr   = (lo_held_reg && !send) ? rd_idx_reg[10:0] - 11'h001 : rd_idx_reg[10:0];
  // ********************
  // avalon-mm slave
  // ********************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg       <= `CTRL_RESET;
      irq_enable_reg <= 3'h0;
    end else if (avs_write && ack_reg) begin
      if (avs_address == `ADDR_CTRL) begin
        ctrl_reg <= avs_writedata[7:0];
      end else if (avs_address == `ADDR_IRQ_ENABLE) begin
        irq_enable_reg <= avs_writedata[2:0];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_reg) begin
      if (avs_address == `ADDR_CTRL) begin
        avs_readdata <= {24'h000000, ctrl_reg};
      end else if (avs_address == `ADDR_STATUS) begin
        avs_readdata <= {13'h0000, long_reg, seg_num_reg, byte_cnt_reg[15:0] == 16'h0000, 1'b0};
      end else if (avs_address == `ADDR_IRQ_STATUS) begin
        avs_readdata <= {29'h00000000, irq_status_reg};
      end else if (avs_address == `ADDR_IRQ_ENABLE) begin
        avs_readdata <= {29'h00000000, irq_enable_reg};
      end else if (avs_address == `ADDR_PKT_COUNT) begin
        avs_readdata <= {16'h0000, pkt_count_reg};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end
  // ********************
  // interrupts
  // ********************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= 3'h0;
    end else begin
      // set wins over a clear in the same cycle
      irq_status_reg <= (irq_status_reg & ~((avs_write && ack_reg && avs_address == `ADDR_IRQ_CLEAR)
                         ? avs_writedata[2:0] : 3'h0)) | {ev_over, ev_err, ev_done};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end
  // ********************
  // byte collection
  // ********************
  assign rx_ready = (state_reg == msg_pkt_pkg::ST_IDLE) || (state_reg == msg_pkt_pkg::ST_COLLECT);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt_reg <= 17'h00000;
      de_reg       <= 1'b0;
      fe_reg       <= 1'b0;
      sub_reg      <= 14'h0000;
      stamp_reg    <= 64'h0;
      msg_done_reg <= 1'b0;
    end else if (take) begin
      if (byte_cnt_reg == 17'h00000) begin
        sub_reg <= rx_byte.subchannel; // RULE1 RULE12
        // time the first byte of the message or segment is taken
        stamp_reg <= ctrl_reg[`CTRL_ABS_BIT] ? abs_time : {16'h0000, rel_time}; // RULE8 RULE9
        de_reg <= rx_byte.data_err;
        fe_reg <= rx_byte.fmt_err | (!rx_byte.start && !long_reg); // RULE11
      end else begin
        de_reg <= de_reg | rx_byte.data_err; // RULE10
        fe_reg <= fe_reg | rx_byte.fmt_err | rx_byte.start; // RULE11
      end
      byte_cnt_reg <= byte_cnt_reg + 17'h00001;
      msg_done_reg <= rx_byte.last;
    end else if (state_reg == msg_pkt_pkg::ST_CHANNEL_SPECIFIC_WORD) begin
      byte_cnt_reg <= 17'h00000;
    end
  end
  msg_byte_mem u_mem (
    .clk     (clk),
    .wr_en   (take),
    .wr_addr (byte_cnt_reg[10:0]),
    .wr_data (rx_byte.data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );
  // ********************
  // framing state machine
  // ********************
  always_comb begin
    if (!long_reg) begin
      body_type = `TYPE_COMPLETE;
    end else if (seg_num_reg == `SEG_FIRST_NUM) begin
      body_type = msg_done_reg ? `TYPE_COMPLETE : `TYPE_SEG_FIRST;
    end else begin
      body_type = msg_done_reg ? `TYPE_SEG_LAST : `TYPE_SEG_MIDDLE;
    end
  end
  assign channel_specific_word = {14'h0000, body_type, (body_type == `TYPE_COMPLETE) ? 16'h0001 : seg_num_reg}; // RULE2 RULE3 RULE4 RULE15
  assign id_word_reg = {de_reg, fe_reg, sub_reg, seg_len_reg[15:0]}; // RULE7 RULE13
  always_comb begin
    case (hdr_idx_reg)
      3'h0:    hdr_half = stamp_reg[15:0];
      3'h1:    hdr_half = stamp_reg[31:16];
      3'h2:    hdr_half = stamp_reg[47:32];
      3'h3:    hdr_half = stamp_reg[63:48];
      3'h4:    hdr_half = id_word_reg[15:0];
      default: hdr_half = id_word_reg[31:16];
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= msg_pkt_pkg::ST_IDLE;
      out_word    <= '0;
      seg_len_reg <= 17'h00000;
      rd_idx_reg  <= 17'h00000;
      hdr_idx_reg <= 3'h0;
      seg_num_reg <= 16'h0000;
      long_reg    <= 1'b0;
      lo_byte_reg <= 8'h00;
      lo_held_reg <= 1'b0;
      pkt_count_reg <= 16'h0000;
      ev_done     <= 1'b0;
      ev_err      <= 1'b0;
      ev_over     <= 1'b0;
    end else begin
      ev_done <= 1'b0;
      ev_err  <= 1'b0;
      ev_over <= 1'b0;
      if (send) begin
        out_word.valid <= 1'b0;
      end
      case (state_reg)
        msg_pkt_pkg::ST_IDLE, msg_pkt_pkg::ST_COLLECT: begin
          if (take) begin
            state_reg <= msg_pkt_pkg::ST_COLLECT;
            if (rx_byte.last || byte_cnt_reg + 17'h00001 == seg_limit) begin
              state_reg   <= msg_pkt_pkg::ST_CHANNEL_SPECIFIC_WORD;
              seg_len_reg <= byte_cnt_reg + 17'h00001;
              hdr_idx_reg <= 3'h0;
              if (!rx_byte.last) begin
                // too long for one body: continue as segments
                long_reg    <= 1'b1;
                seg_num_reg <= long_reg ? seg_num_reg + 16'h0001 : `SEG_FIRST_NUM; // RULE5
              end else if (long_reg) begin
                seg_num_reg <= seg_num_reg + 16'h0001; // RULE5
              end
              if (long_reg && seg_num_reg == 16'hffff && !rx_byte.last) begin
                ev_over <= 1'b1; // RULE6
              end
            end
          end
        end
        msg_pkt_pkg::ST_CHANNEL_SPECIFIC_WORD: begin
          if (send) begin
            out_word.valid <= 1'b1;
            out_word.first <= hdr_idx_reg == 3'h0;
            out_word.last  <= 1'b0;
            out_word.data  <= hdr_idx_reg == 3'h0 ? channel_specific_word[15:0] : channel_specific_word[31:16];
            hdr_idx_reg    <= hdr_idx_reg + 3'h1;
            if (hdr_idx_reg == 3'h1) begin
              state_reg   <= msg_pkt_pkg::ST_HDR;
              hdr_idx_reg <= 3'h0;
            end
          end
        end
        msg_pkt_pkg::ST_HDR: begin
          if (send) begin
            out_word.valid <= 1'b1;
            out_word.first <= 1'b0;
            out_word.data  <= hdr_half;
            hdr_idx_reg    <= hdr_idx_reg + 3'h1;
            rd_idx_reg     <= 17'h00000;
            lo_held_reg    <= 1'b0;
            if (hdr_idx_reg == `HDR_WORDS - 3'h1) begin
              state_reg <= msg_pkt_pkg::ST_BODY;
            end
          end
        end
        msg_pkt_pkg::ST_BODY: begin
          // pair bytes: earlier low, later high, filler zero
          if (!lo_held_reg) begin
            if (rd_idx_reg != 17'h00000) begin
              lo_byte_reg <= rd_data;
              lo_held_reg <= 1'b1;
            end
            rd_idx_reg <= rd_idx_reg + 17'h00001;
          end else if (send) begin
            out_word.valid <= 1'b1;
            out_word.data  <= (rd_idx_reg > seg_len_reg) ? {8'h00, lo_byte_reg} : {rd_data, lo_byte_reg}; // RULE14
            out_word.last  <= rd_idx_reg >= seg_len_reg;
            lo_held_reg    <= 1'b0;
            rd_idx_reg     <= rd_idx_reg + 17'h00001;
            if (rd_idx_reg >= seg_len_reg) begin
              state_reg <= msg_pkt_pkg::ST_DONE;
            end
          end
        end
        default: begin
          state_reg     <= msg_pkt_pkg::ST_IDLE;
          pkt_count_reg <= pkt_count_reg + 16'h0001;
          ev_done       <= 1'b1;
          ev_err        <= de_reg | fe_reg;
          if (msg_done_reg) begin
            long_reg <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule

/* verification/msg_packetizer_properties.sv */
// port assertions for the message packetizer
// assumes binding onto msg_packetizer, single clock
`timescale 1ns/1ps
module msg_packetizer_checker (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // stream and bus
  input wire msg_pkt_pkg::out_word_t out_word,
  input wire logic                   word_ready,
  input wire logic [3:0]             avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic                   irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ***************
  // word position helpers
  // ***************
  logic        h;
  logic [15:0] wcnt;
  logic [15:0] w0;
  logic [15:0] idlen;
  logic [15:0] segnum;
  assign h = out_word.valid && word_ready;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wcnt <= 16'h0;
    else if (h) wcnt <= out_word.last ? 16'h0 : wcnt + 16'h1;
  end
  always_ff @(posedge clk) begin
    if (h && wcnt == 16'h0) w0 <= out_word.data;
    if (h && wcnt == 16'h6) idlen <= out_word.data;
    if (h && wcnt == 16'h1 && out_word.data[1:0] != 2'h0) segnum <= w0;
  end
  a_word_held: assert property (out_word.valid && !word_ready |=> out_word.valid && $stable(out_word))
    else $error("output word changed while stalled");
  a_first_flag: assert property (out_word.valid |-> out_word.first == (wcnt == 16'h0))
    else $error("first flag off the opening word");
  a_channel_specific_word_rsvd: assert property (h && wcnt == 16'h1 |-> out_word.data[15:2] == 14'h0)
    else $error("reserved header bits set");
  a_complete_cnt: assert property (h && wcnt == 16'h1 && out_word.data[1:0] == 2'h0 |-> w0 == 16'h1)
    else $error("complete count wrong");
  a_seg_first: assert property (h && wcnt == 16'h1 && out_word.data[1:0] == 2'h1 |-> w0 == 16'h1)
    else $error("first segment number wrong");
  a_seg_step: assert property (h && wcnt == 16'h1 && out_word.data[1] |-> w0 == segnum + 16'h1)
    else $error("segment number did not step by one");
  a_pkt_len: assert property (h && out_word.last |-> {1'b0, wcnt} == 17'h7 + ((17'(idlen) + 17'h1) >> 1))
    else $error("packet length disagrees with id word");
  a_wait_one: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one cycle");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h5 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  cover property (h && out_word.last);
  cover property (h && wcnt == 16'h1 && out_word.data[1:0] == 2'h3);
  cover property ($rose(irq));
endmodule
bind msg_packetizer msg_packetizer_checker chk (.clk(clk), .rst_n(rst_n), .out_word(out_word),
  .word_ready(word_ready), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

/* verification/rec_sink.sv */
// recording stream sink model collecting words in a queue
// assumes stall halves its acceptance rate
`timescale 1ns/1ps
module rec_sink (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // stream
  input  wire msg_pkt_pkg::out_word_t out_word,
  output logic                        word_ready,
  // pacing
  input  wire logic                   stall
);
  logic [17:0] q[$];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) word_ready <= 1'b0;
    else word_ready <= stall ? !word_ready : 1'b1;
  end
  always @(posedge clk) begin
    if (rst_n && out_word.valid && word_ready) q.push_back({out_word.first, out_word.last, out_word.data});
  end
endmodule

/* verification/tb.sv */
// self-checking bench for the message packetizer
// assumes rec_sink as stream partner
`timescale 1ns/1ps
module tb;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  msg_pkt_pkg::rx_byte_t  rx_byte = '0;
  logic                   rx_valid = 1'b0;
  logic                   rx_ready;
  logic [47:0]            rel_time = 48'h1234_5678_9abc;
  logic [63:0]            abs_time = 64'h0fed_cba9_8765_4321;
  msg_pkt_pkg::out_word_t out_word;
  logic                   word_ready;
  logic                   stall = 1'b0;
  logic [3:0]             avs_address = 4'h0;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [31:0]            avs_writedata = 32'h0;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   irq;
  logic [31:0]            rd;
  logic [47:0]            t0;
  int                     err_count = 0;
  int                     compares = 0;
  int                     p = 0;
  always #2 clk = ~clk;
  // free-running relative counter so the stamp shows when the first byte was taken
  always @(posedge clk) rel_time <= rel_time + 48'h000000000001;
  msg_packetizer uut (.clk(clk), .rst_n(rst_n), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rel_time(rel_time), .abs_time(abs_time), .out_word(out_word), .word_ready(word_ready),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
  rec_sink snk (.clk(clk), .rst_n(rst_n), .out_word(out_word), .word_ready(word_ready), .stall(stall));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic send(input int n, input logic [13:0] sc, input logic de, input logic fe);
    for (int k = 0; k < n; k++) begin
      rx_byte <= '{start: k == 0, last: k == n - 1, data: k[7:0], subchannel: sc, data_err: de, fmt_err: fe};
      rx_valid <= 1'b1;
      @(posedge clk);
      while (rx_ready !== 1'b1) @(posedge clk);
      if (k == 0) t0 = rel_time;
    end
    rx_valid <= 1'b0;
  endtask
  task automatic chk_pkt(input logic [31:0] channel_specific_word, input logic [31:0] idw, input logic [63:0] ts, input int base);
    int n;
    n = idw[15:0];
    while (snk.q.size() < p + 8 + (n + 1) / 2) @(posedge clk);
    cmp("first", 32'h1, {31'h0, snk.q[p][17]});
    cmp("channel_specific_word", channel_specific_word, {snk.q[p+1][15:0], snk.q[p][15:0]});
    cmp("ts", ts[63:32], {snk.q[p+5][15:0], snk.q[p+4][15:0]});
    cmp("ts", ts[31:0], {snk.q[p+3][15:0], snk.q[p+2][15:0]});
    cmp("id", idw, {snk.q[p+7][15:0], snk.q[p+6][15:0]});
    for (int w = 0; w < (n + 1) / 2; w++)
      cmp("payload", {16'h0, (2*w+1 < n) ? 8'(base+2*w+1) : 8'h00, 8'(base+2*w)}, {16'h0, snk.q[p+8+w][15:0]});
    p = p + 8 + (n + 1) / 2;
    cmp("last", 32'h1, {31'h0, snk.q[p-1][16]});
  endtask
  task automatic t_regs();
    bus(1'b0, 4'h0, 32'h0);
    cmp("ctrl", 32'h0, rd);
    bus(1'b0, 4'h5, 32'h0);
    cmp("count", 32'h0, rd);
    bus(1'b0, 4'hf, 32'h0);
    cmp("unmapped", 32'h0, rd);
    $display("t_regs done");
  endtask
  task automatic t_complete(input logic ab, input int n, input logic [13:0] sc, input logic de, input logic fe);
    bus(1'b1, 4'h0, {31'h0, ab});
    bus(1'b1, 4'h3, 32'h1);
    send(n, sc, de, fe);
    chk_pkt(32'h1, {de, fe, sc, 16'(n)}, ab ? abs_time : {16'h0, t0}, 0);
    repeat (3) @(posedge clk);
    cmp("irq", 32'h1, {31'h0, irq});
    bus(1'b0, 4'h2, 32'h0);
    cmp("done", 32'h1, {31'h0, rd[0]});
    bus(1'b1, 4'h4, 32'h7);
    repeat (2) @(posedge clk);
    cmp("irq", 32'h0, {31'h0, irq});
    $display("t_complete done");
  endtask
  task automatic t_long();
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b1, 4'h3, 32'h0);
    stall <= 1'b1;
    send(300, 14'h2a, 1'b0, 1'b0);
    chk_pkt(32'h0001_0001, 32'h002a_0080, abs_time, 0);
    chk_pkt(32'h0003_0002, 32'h002a_0080, abs_time, 128);
    chk_pkt(32'h0002_0003, 32'h002a_002c, abs_time, 256);
    cmp("masked irq", 32'h0, {31'h0, irq});
    bus(1'b0, 4'h5, 32'h0);
    cmp("count", 32'h5, rd);
    $display("t_long done");
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_complete(1'b0, 3, 14'h005, 1'b1, 1'b0);
    t_complete(1'b1, 4, 14'h3fff, 1'b0, 1'b1);
    t_long();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule
